// file: cnt_timer.sv
// Four-channel 8-bit down-counter/timer with bus cycle decode, zero-count pulses,
// fixed channel interrupt priority, daisy-chain in/out and return-opcode decode.
// Assumes all pins are synchronous to ref_clk and an outside wire resolves enables.
// Behaviour
// - A channel read returns its live down-count and leaves it unchanged.
// - Two channel-select inputs pick one of four channels for reads and writes.
// - Write qualifier made inside when read was high in the first period.
// - Written byte captured on the clock edge starting the third period.
// - External trigger edge starts the timer on the second following clock edge.
// - A trigger edge too late for one edge slips start by one more cycle.
// - Automatic trigger mode starts timing without any trigger edge.
// - Counter mode decrements once per synchronised active input edge.
// - A count edge missing the sampling window decrements one cycle later.
// - Reaching zero on channels 0 to 2 gives a one-cycle high pulse right after that edge.
// - Channel 0 has highest interrupt priority, channel 3 lowest.
// - A channel under service blocks lower ones; higher ones still interrupt.
// - An enabled channel requests an interrupt at each zero count.
// - Vector is five programmed high bits, channel code, then a zero.
// - Vector driven on acknowledge when I/O request is low and chain-in high.
// - Request status takes no new requests while the first-cycle indicator is low.
// - Fetched pair ED then 4D releases the channel under service.
// - Chain-out high only with chain-in high and no channel in service.
// - Channel 0 byte with bit 0 clear loads vector high bits, ignoring bits 1-2.
module cnt_timer
(
    input  wire logic       ref_clk,            // System clock, 20 MHz
    input  wire logic       rstn,               // Synchronous reset, active low
    input  wire logic       chip_enable_n,      // Chip enable, active low
    input  wire logic       io_request_n,       // I/O request, active low
    input  wire logic       read_n,             // Read strobe, active low
    input  wire logic       first_cycle_n,      // First machine cycle, active low
    input  wire logic       channel_select_lo,  // Channel select bit 0
    input  wire logic       channel_select_hi,  // Channel select bit 1
    input  wire logic [7:0] data_in,            // Data bus as seen at the pins
    output logic      [7:0] data_out,           // Data bus drive value
    output logic            data_oe_n,          // Data bus enable, low while driving
    input  wire logic [3:0] ext_count_trigger,  // Per-channel count or trigger input
    output logic      [2:0] zero_count_pulse,   // Zero-count pulses, channels 0 to 2
    output logic            int_out,            // Open-drain request level, always low
    output logic            int_oe_n,           // Request enable, low while requesting
    input  wire logic       priority_chain_in,  // Daisy chain enable in
    output logic            priority_chain_out  // Daisy chain enable out
);

    // Bus history and decode
    logic       io_prev;
    logic       read_prev;
    logic       m1_prev;
    logic [1:0] sel;
    logic       io_start;
    logic       wr_now;
    logic       rd_act;
    logic       ack_act;
    logic       ack_start;

    assign sel       = {channel_select_hi, channel_select_lo};
    assign io_start  = ~io_request_n & io_prev;
    assign rd_act    = ~io_request_n & ~chip_enable_n & ~read_n & first_cycle_n;
    assign wr_now    = io_start & ~chip_enable_n & first_cycle_n & read_n & read_prev;
    assign ack_act   = ~io_request_n & ~first_cycle_n & priority_chain_in;
    assign ack_start = ack_act & io_prev;

    // Sample bus strobes one cycle back
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            io_prev   <= 1'b1;
            read_prev <= 1'b1;
            m1_prev   <= 1'b1;
        end
        else
        begin
            io_prev   <= io_request_n;
            read_prev <= read_n;
            m1_prev   <= first_cycle_n;
        end
    end

    // Per-channel state
    logic [7:0] ctrl  [cnt_timer_pkg::NUM_CH];
    logic [7:0] tconst[cnt_timer_pkg::NUM_CH];
    logic [7:0] count [cnt_timer_pkg::NUM_CH];
    logic [7:0] pre   [cnt_timer_pkg::NUM_CH];
    logic [3:0] tc_next;
    logic [3:0] armed;
    logic [3:0] run;
    logic [3:0] trig_q;
    logic [3:0] trig_prev;
    logic [3:0] edge_hit;
    logic [3:0] dec;
    logic [3:0] zc;
    logic [3:0] ip;
    logic [3:0] hold;
    logic [3:0] ius;
    logic [3:0] blk;
    logic [3:0] open_req;
    logic [3:0] ack_set;
    logic [3:0] rel;
    logic [4:0] vec_hi;
    logic [1:0] win;

    genvar i;
    generate
        for (i = 0; i < cnt_timer_pkg::NUM_CH; i++)
        begin : g_ch
            logic wr_ch;
            logic tick;
            logic counter_mode;

            assign wr_ch        = wr_now & (sel == 2'(i));
            assign counter_mode = ctrl[i][cnt_timer_pkg::CTL_COUNTER];
            // Active edge on the registered pin sample
            assign edge_hit[i]  = (trig_q[i] != trig_prev[i])
                                  & (trig_q[i] == ctrl[i][cnt_timer_pkg::CTL_RISING]);
            assign tick         = run[i] & ~counter_mode & (pre[i] == 8'h00);
            assign dec[i]       = run[i] & (counter_mode ? edge_hit[i] : tick);

            // Trigger pin history
            always_ff @(posedge ref_clk)
            begin
                if (!rstn)
                begin
                    trig_q[i]    <= 1'b0;
                    trig_prev[i] <= 1'b0;
                end
                else
                begin
                    trig_q[i]    <= ext_count_trigger[i];
                    trig_prev[i] <= trig_q[i];
                end
            end

            // Control word and time constant loading, start and stop
            always_ff @(posedge ref_clk)
            begin
                if (!rstn)
                begin
                    ctrl[i]    <= cnt_timer_pkg::CTRL_RESET;
                    tconst[i]  <= cnt_timer_pkg::COUNT_RESET;
                    tc_next[i] <= 1'b0;
                    armed[i]   <= 1'b0;
                    run[i]     <= 1'b0;
                end
                else if (wr_ch && tc_next[i])
                begin
                    tconst[i]  <= data_in;
                    tc_next[i] <= 1'b0;
                    if (!run[i])
                    begin
                        run[i]   <= counter_mode | ~ctrl[i][cnt_timer_pkg::CTL_EXT_TRIG];
                        armed[i] <= ~counter_mode & ctrl[i][cnt_timer_pkg::CTL_EXT_TRIG];
                    end
                end
                else if (wr_ch && data_in[cnt_timer_pkg::CTL_IS_CTRL])
                begin
                    ctrl[i]    <= data_in;
                    tc_next[i] <= data_in[cnt_timer_pkg::CTL_TC_NEXT];
                    if (data_in[cnt_timer_pkg::CTL_SW_RESET])
                    begin
                        run[i]   <= 1'b0;
                        armed[i] <= 1'b0;
                    end
                end
                else if (armed[i] && edge_hit[i])
                begin
                    armed[i] <= 1'b0;
                    run[i]   <= 1'b1;
                end
            end

            // Down-counter, prescaler and zero pulse
            always_ff @(posedge ref_clk)
            begin
                if (!rstn)
                begin
                    count[i] <= cnt_timer_pkg::COUNT_RESET;
                    pre[i]   <= cnt_timer_pkg::PRE_16_LOAD;
                    zc[i]    <= 1'b0;
                end
                else if (wr_ch && tc_next[i] && !run[i])
                begin
                    count[i] <= data_in;
                    pre[i]   <= ctrl[i][cnt_timer_pkg::CTL_PRE_256] ? cnt_timer_pkg::PRE_256_LOAD
                                                                     : cnt_timer_pkg::PRE_16_LOAD;
                    zc[i]    <= 1'b0;
                end
                else
                begin
                    if (tick)
                        pre[i] <= ctrl[i][cnt_timer_pkg::CTL_PRE_256] ? cnt_timer_pkg::PRE_256_LOAD
                                                                       : cnt_timer_pkg::PRE_16_LOAD;
                    else if (run[i] && !counter_mode)
                        pre[i] <= pre[i] - 8'h01;
                    // Zero reloads the time constant at once
                    if (dec[i])
                        count[i] <= (count[i] == 8'h01) ? tconst[i] : count[i] - 8'h01;
                    zc[i] <= dec[i] & (count[i] == 8'h01);
                end
            end

            // Request pending, held back while the first-cycle indicator is low
            always_ff @(posedge ref_clk)
            begin
                if (!rstn)
                begin
                    ip[i]   <= 1'b0;
                    hold[i] <= 1'b0;
                    ius[i]  <= 1'b0;
                end
                else
                begin
                    if (first_cycle_n)
                        ip[i] <= (ip[i] & ~ack_set[i]) | hold[i]
                                 | (zc[i] & ctrl[i][cnt_timer_pkg::CTL_INT_EN]);
                    else
                        ip[i] <= ip[i] & ~ack_set[i];
                    hold[i] <= ~first_cycle_n & (hold[i] | (zc[i] & ctrl[i][cnt_timer_pkg::CTL_INT_EN]));
                    ius[i]  <= (ius[i] & ~rel[i]) | ack_set[i];
                end
            end

            // Service at or above this channel blocks it
            if (i == 0)
            begin : g_blk0
                assign blk[i] = ius[i];
            end
            else
            begin : g_blkn
                assign blk[i] = blk[i-1] | ius[i];
            end
            assign open_req[i] = ip[i] & ~blk[i];
            assign ack_set[i]  = ack_start & (win == 2'(i)) & (|open_req);
        end
    endgenerate

    // Fixed priority encoder, channel 0 first
    logic [7:0] vec_win;
    logic [7:0] vec_held;
    logic [1:0] ack_chan;
    logic       ack_busy;

    assign win      = open_req[0] ? 2'd0 : open_req[1] ? 2'd1 : open_req[2] ? 2'd2 : 2'd3;
    assign vec_win  = {vec_hi, win, 1'b0};
    assign vec_held = {vec_hi, ack_chan, 1'b0};

    // Vector high bits from channel 0 non-control writes
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            vec_hi <= cnt_timer_pkg::VEC_RESET;
        else if (wr_now && sel == 2'd0 && !tc_next[0] && !data_in[cnt_timer_pkg::CTL_IS_CTRL])
            vec_hi <= data_in[7:cnt_timer_pkg::VEC_HI_LSB];
    end

    // Acknowledge tracking
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            ack_busy <= 1'b0;
            ack_chan <= 2'd0;
        end
        else if (ack_start && |open_req)
        begin
            ack_busy <= 1'b1;
            ack_chan <= win;
        end
        else if (io_request_n)
            ack_busy <= 1'b0;
    end

    // Data bus drive: counts on reads, vector on acknowledge
    logic       next_oe_n;
    logic [7:0] next_data;
    assign next_oe_n = ~(rd_act | (ack_start & |open_req) | (ack_busy & ack_act));
    assign next_data = (ack_start & |open_req) ? vec_win :
                       ack_busy                ? vec_held : count[sel];

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            data_out  <= 8'h00;
            data_oe_n <= 1'b1;
        end
        else
        begin
            data_out  <= next_data;
            data_oe_n <= next_oe_n;
        end
    end

    // Opcode fetch watch for the return pair
    logic [7:0] fetch_byte;
    logic       fetched;
    logic       ed_seen;
    logic       m1_end;
    assign m1_end = first_cycle_n & ~m1_prev;
    assign rel    = (m1_end & fetched & ed_seen & (fetch_byte == cnt_timer_pkg::RETURN_FROM_ISR_CODE_SECOND))
                    ? (ius & ~(ius - 4'h1)) : 4'h0;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            fetch_byte <= 8'h00;
            fetched    <= 1'b0;
            ed_seen    <= 1'b0;
        end
        else if (!first_cycle_n && !read_n && io_request_n)
        begin
            fetch_byte <= data_in;
            fetched    <= 1'b1;
        end
        else if (m1_end)
        begin
            fetched <= 1'b0;
            if (fetched)
                ed_seen <= (fetch_byte == cnt_timer_pkg::RETURN_FROM_ISR_CODE_FIRST);
        end
    end

    // Request pin and daisy chain
    logic int_act;
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            int_act <= 1'b0;
        else
            int_act <= |open_req & priority_chain_in;
    end
    assign int_out            = 1'b0;
    assign int_oe_n           = ~int_act;
    assign priority_chain_out = priority_chain_in & ~|ius;
    assign zero_count_pulse   = zc[2:0];

    // Checks
    rd_data_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_act && !ack_busy |=> data_out == $past(count[sel]) && !data_oe_n)
        else $error("read data mismatch");
    wr_ctrl_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_now && sel == 2'd1 && !tc_next[1] && data_in[0] |=> ctrl[1] == $past(data_in))
        else $error("control byte not captured");
    auto_start_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_now && sel == 2'd0 && tc_next[0] && !run[0] && !ctrl[0][3] |=> run[0])
        else $error("auto timer did not start");
    trig_start_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        armed[0] && !wr_now && ext_count_trigger[0] == ctrl[0][4] && trig_q[0] != ctrl[0][4]
        ##1 !wr_now |=> run[0])
        else $error("trigger start late");
    cnt_dec_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        run[2] && ctrl[2][6] && edge_hit[2] && count[2] > 8'h01 && !wr_now |=> count[2] == $past(count[2]) - 8'h01)
        else $error("counter edge lost");
    zc_pulse_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        zero_count_pulse[0] |-> $past(dec[0]) && $past(count[0]) == 8'h01 ##1 !zero_count_pulse[0] || dec[0])
        else $error("zero pulse wrong");
    vec_form_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        ack_start && |open_req |=> !data_oe_n && data_out == {vec_hi, $past(win), 1'b0})
        else $error("vector malformed");
    prio_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        open_req[0] |-> win == 2'd0)
        else $error("channel 0 not first");
    freeze_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !first_cycle_n && $past(!first_cycle_n) |-> (ip & ~$past(ip)) == 4'h0)
        else $error("request changed during first cycle");
    chain_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        priority_chain_out |-> priority_chain_in && ius == 4'h0)
        else $error("chain out while serviced");
    hiz_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        io_request_n && $past(io_request_n) |-> data_oe_n)
        else $error("bus driven while idle");
    return_from_isr_code_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        rel != 4'h0 |=> ius == ($past(ius) & ~$past(rel)))
        else $error("service not released");

    ack_c:  cover property (@(posedge ref_clk) ack_start && |open_req);
    return_from_isr_code_c: cover property (@(posedge ref_clk) rel != 4'h0);
    zc_c:   cover property (@(posedge ref_clk) zc[3]);
    nest_c: cover property (@(posedge ref_clk) ius[2] && ack_set[0]);

endmodule

// file: cnt_timer_pkg.sv
// Constants shared by the four-channel counter/timer design.
// Assumes an 8-bit processor bus sampled synchronously to ref_clk.
package cnt_timer_pkg;

    // Channel count and select width
    localparam int          NUM_CH       = 4;
    localparam int          SEL_W        = 2;

    // Channel control word bit positions
    localparam int          CTL_INT_EN   = 7;
    localparam int          CTL_COUNTER  = 6;
    localparam int          CTL_PRE_256  = 5;
    localparam int          CTL_RISING   = 4;
    localparam int          CTL_EXT_TRIG = 3;
    localparam int          CTL_TC_NEXT  = 2;
    localparam int          CTL_SW_RESET = 1;
    localparam int          CTL_IS_CTRL  = 0;

    // Values after reset
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  COUNT_RESET  = 8'h00;
    localparam logic [4:0]  VEC_RESET    = 5'h00;

    // Prescaler reload values, one less than the division factor
    localparam logic [7:0]  PRE_16_LOAD  = 8'h0f;
    localparam logic [7:0]  PRE_256_LOAD = 8'hff;

    // Return-from-interrupt opcode pair
    localparam logic [7:0]  RETURN_FROM_ISR_CODE_FIRST   = 8'hed;
    localparam logic [7:0]  RETURN_FROM_ISR_CODE_SECOND  = 8'h4d;

    // Interrupt vector field layout
    localparam int          VEC_HI_LSB   = 3;
    localparam int          VEC_CH_LSB   = 1;

    // Cycles from trigger edge at the pins to timer start
    localparam int          TRIG_START_CYCLES = 2;

endpackage

// file: bus_master_model.sv
// Processor bus master model for the counter/timer pins.
// Assumes the bench calls its tasks; pins change at falling edges.
module bus_master_model
(
    input  wire logic       clk,     // System clock
    input  wire logic [7:0] bus,     // Resolved data bus
    output logic            ce_n,    // Chip enable
    output logic            io_request_n_n,  // I/O request
    output logic            rd_n,    // Read strobe
    output logic            m1_n,    // First machine cycle
    output logic      [1:0] sel,     // Channel select
    output logic      [7:0] dq_drv,  // Bus drive value
    output logic            dq_en    // Bus drive enable
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus; first cycle stays high for reads and writes
    task automatic idle();
        @(negedge clk);
        ce_n = 1;
        io_request_n_n = 1;
        rd_n = 1;
        m1_n = 1;
        dq_en = 0;
    endtask

    initial
    begin
        {ce_n, io_request_n_n, rd_n, m1_n} = 4'hf;
        sel = 2'h0;
        dq_drv = 8'h00;
        dq_en = 0;
    end

    // Write: request low for one edge, read strobe high throughout
    task automatic wr(input logic [1:0] ch, input logic [7:0] b);
        @(negedge clk);
        sel = ch;
        dq_drv = b;
        dq_en = 1;
        ce_n = 0;
        io_request_n_n = 0;
        idle();
    endtask

    // Read: strobes low, no wait states, byte taken after two edges
    task automatic rd(input logic [1:0] ch, output logic [7:0] b);
        @(negedge clk);
        sel = ch;
        ce_n = 0;
        io_request_n_n = 0;
        rd_n = 0;
        repeat (2) @(negedge clk);
        b = bus;
        idle();
    endtask

    // Acknowledge with two wait states before the vector is taken
    task automatic ack(output logic [7:0] b);
        @(negedge clk);
        m1_n = 0;
        @(negedge clk);
        io_request_n_n = 0;
        repeat (3) @(negedge clk);
        b = bus;
        idle();
    endtask

    // Opcode fetch of one byte
    task automatic fetch(input logic [7:0] op);
        @(negedge clk);
        m1_n = 0;
        rd_n = 0;
        dq_drv = op;
        dq_en = 1;
        @(negedge clk);
        idle();
    endtask
endmodule

// file: tb.sv
// Self-checking bench for the four-channel counter/timer.
// Assumes the bus master model and a 20 MHz clock.
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("ERROR %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       ref_clk, rstn, ce_n, io_request_n_n, rd_n, m1_n, dq_en, chain_in, chain_out;
    logic       data_oe_n, int_oe_n, int_lvl, drove;
    logic [1:0] sel;
    logic [2:0] zcp;
    logic [3:0] trig;
    logic [7:0] bus, data_out, dq_drv, v;
    int         n_mismatch, num_checks, n;
    int         zc [3];

    // Wire level: device, master, else a changing pattern
    assign bus = !data_oe_n ? data_out : (dq_en ? dq_drv : (8'h5a ^ {8{ref_clk}}));

    cnt_timer cnt_timer_inst (.ref_clk(ref_clk), .rstn(rstn), .chip_enable_n(ce_n),
        .io_request_n(io_request_n_n), .read_n(rd_n), .first_cycle_n(m1_n),
        .channel_select_lo(sel[0]), .channel_select_hi(sel[1]), .data_in(bus),
        .data_out(data_out), .data_oe_n(data_oe_n), .ext_count_trigger(trig),
        .zero_count_pulse(zcp), .int_out(int_lvl), .int_oe_n(int_oe_n),
        .priority_chain_in(chain_in), .priority_chain_out(chain_out));

    bus_master_model bus_master_model_inst (.clk(ref_clk), .bus(bus), .ce_n(ce_n),
        .io_request_n_n(io_request_n_n), .rd_n(rd_n), .m1_n(m1_n), .sel(sel), .dq_drv(dq_drv),
        .dq_en(dq_en));

    // Clock, 50 ns period
    initial
    begin
        ref_clk = 0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Zero pulse cycle counts and bus drive history
    always @(posedge ref_clk)
    begin
        zc[0] += zcp[0];
        zc[1] += zcp[1];
        zc[2] += zcp[2];
        if (!data_oe_n)
            drove = 1;
    end

    task automatic tally_and_finish();
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Count source pulses, two cycles high, three low between pulses
    task automatic pulse(input int ch, input int k);
        repeat (k)
        begin
            @(negedge ref_clk);
            trig[ch] = 1;
            repeat (2) @(negedge ref_clk);
            trig[ch] = 0;
            repeat (2) @(negedge ref_clk);
        end
    endtask

    // Idle outputs after reset and chain pass-through
    task automatic t_reset();
        `CHK(data_oe_n, 1'b1);
        `CHK(int_oe_n, 1'b1);
        `CHK(int_lvl, 1'b0);
        chain_in = 0;
        #1 `CHK(chain_out, 1'b0);
        @(negedge ref_clk);
        chain_in = 1;
        #1 `CHK(chain_out, 1'b1);
    endtask

    // Each channel keeps its own constant; reads do not disturb it
    task automatic t_select();
        for (int c = 0; c < 4; c++)
        begin
            bus_master_model_inst.wr(2'(c), 8'h55);
            bus_master_model_inst.wr(2'(c), 8'h10 + 8'(c));
        end
        for (int c = 0; c < 4; c++)
        begin
            bus_master_model_inst.rd(2'(c), v);
            `CHK(v, 8'h10 + 8'(c));
            bus_master_model_inst.rd(2'(c), v);
            `CHK(v, 8'h10 + 8'(c));
        end
    endtask

    // Counter decrements, zero pulse and reload
    task automatic t_count();
        pulse(1, 2);
        bus_master_model_inst.rd(2'h1, v);
        `CHK(v, 8'h0f);
        // Software reset first so the new constant loads the count at once
        bus_master_model_inst.wr(2'h2, 8'h57);
        bus_master_model_inst.wr(2'h2, 8'h02);
        zc[2] = 0;
        pulse(2, 1);
        `CHK(zc[2], 0);
        pulse(2, 1);
        `CHK(zc[2], 1);
        bus_master_model_inst.rd(2'h2, v);
        `CHK(v, 8'h02);
    endtask

    // External trigger timer, prescale 16, constant 3
    task automatic t_timer();
        bus_master_model_inst.wr(2'h0, 8'h1f);
        bus_master_model_inst.wr(2'h0, 8'h03);
        repeat (10) @(negedge ref_clk);
        bus_master_model_inst.rd(2'h0, v);
        `CHK(v, 8'h03);
        n = 0;
        zc[0] = 0;
        trig[0] = 1;
        while (zcp[0] !== 1'b1 && n < 100)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        `CHK(n inside {[48:54]}, 1'b1);
        // Let the pulse be counted, then it must be gone again
        repeat (2) @(negedge ref_clk);
        `CHK(zc[0], 1);
        `CHK(zcp[0], 1'b0);
        trig[0] = 0;
        bus_master_model_inst.wr(2'h0, 8'h03);
    endtask

    // Automatic start with no trigger edge
    task automatic t_auto();
        bus_master_model_inst.wr(2'h3, 8'h07);
        bus_master_model_inst.wr(2'h3, 8'h02);
        repeat (20) @(negedge ref_clk);
        bus_master_model_inst.rd(2'h3, v);
        `CHK(v, 8'h01);
        bus_master_model_inst.wr(2'h3, 8'h03);
    endtask

    // Priority, vectors, blocking, chain and return decode
    task automatic t_irq();
        bus_master_model_inst.wr(2'h0, 8'ha6);
        // Software reset so the constant of 1 loads the running counters
        for (int c = 1; c < 3; c++)
        begin
            bus_master_model_inst.wr(2'(c), 8'hd7);
            bus_master_model_inst.wr(2'(c), 8'h01);
        end
        pulse(2, 1);
        pulse(1, 1);
        `CHK(zc[1], 1);
        `CHK(int_oe_n, 1'b0);
        bus_master_model_inst.ack(v);
        `CHK(v, 8'ha2);
        `CHK(chain_out, 1'b0);
        `CHK(int_oe_n, 1'b1);
        bus_master_model_inst.fetch(8'hed);
        bus_master_model_inst.fetch(8'h4d);
        // Release happens on the rising edge after the second fetch ends
        @(negedge ref_clk);
        `CHK(chain_out, 1'b1);
        chain_in = 0;
        drove = 0;
        bus_master_model_inst.ack(v);
        `CHK(drove, 1'b0);
        chain_in = 1;
        bus_master_model_inst.ack(v);
        `CHK(v, 8'ha4);
        bus_master_model_inst.fetch(8'hed);
        bus_master_model_inst.fetch(8'h4d);
        @(negedge ref_clk);
        `CHK(chain_out, 1'b1);
    endtask

    // Main sequence
    initial
    begin
        rstn = 0;
        trig = 4'h0;
        chain_in = 1;
        drove = 0;
        repeat (5) @(negedge ref_clk);
        rstn = 1;
        t_reset();
        t_select();
        t_count();
        t_timer();
        t_auto();
        t_irq();
        tally_and_finish();
    end

    // Watchdog
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
